// >>> hw/ifp_pkg.sv
// shared constants, register layouts and types for the interrupt and fault power-down block
package ifp_pkg;

	// ************************************************
	// clock and pulse timing
	// ************************************************
	localparam int unsigned CLK_HZ = 100_000_000; // mclk rate
	localparam int unsigned PULSE_WIDTH_MS = 2; // irq pulse width, typical
	localparam int unsigned PULSE_PERIOD_MS = 4; // irq repeat period, typical
	localparam int unsigned PULSE_WIDTH_CYCLES = PULSE_WIDTH_MS * (CLK_HZ / 1000);
	localparam int unsigned PULSE_PERIOD_CYCLES = PULSE_PERIOD_MS * (CLK_HZ / 1000);
	localparam int unsigned PULSE_CNT_W = 19; // holds the 4 ms period count

	// ************************************************
	// register indices (byte address is four times the index)
	// ************************************************
	localparam logic [7:0] IDX_RATIO_HIGH = 8'h40; // upper six ratio bits
	localparam logic [7:0] IDX_RATIO_LOW = 8'h41; // low ratio byte
	localparam logic [7:0] IDX_IRQ_CONFIG = 8'h42; // irq and channel fault config
	localparam logic [7:0] IDX_DAC_FAULT = 8'h43; // dac fault config and status
	localparam logic [7:0] IDX_IRQ_MASK = 8'h60; // 1 masks a source
	localparam logic [7:0] IDX_LATCHED = 8'h61; // latched flags
	localparam logic [7:0] IDX_LIVE = 8'h62; // live flags
	localparam logic [7:0] IDX_PD_RELEASE = 8'h63; // manual recovery strobes
	localparam int unsigned ADDR_W = 12; // apb address width
	localparam int unsigned REL_CHAN_BIT = 0; // release bit for channel power-down
	localparam int unsigned REL_DAC_BIT = 1; // release bit for dac power-down

	// ************************************************
	// reset values
	// ************************************************
	localparam logic [7:0] IRQ_CONFIG_RESET = 8'h00;
	localparam logic [7:0] DAC_FAULT_RESET = 8'h54;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

	// ************************************************
	// source bit positions in the flag vectors
	// ************************************************
	localparam int unsigned SRC_CHAN_N = 5; // channel and micbias faults, bits 4..0
	localparam int unsigned SRC_DAC_VG = 5; // dac driver voltage fault
	localparam int unsigned SRC_DAC_SC = 6; // dac short circuit fault
	localparam int unsigned SRC_AREG_SC = 7; // analog regulator short

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [1:0] {
		EV_LATCHED = 2'h0,
		EV_LIVE = 2'h1,
		EV_PERIODIC = 2'h2,
		EV_ONESHOT = 2'h3
	} ifp_event_t;

	typedef enum logic [1:0] {
		PD_NONE = 2'h0,
		PD_UNMASKED = 2'h1,
		PD_ALL = 2'h2,
		PD_RESERVED = 2'h3
	} ifp_pd_sel_t;

	typedef struct packed {
		logic polarity; // bit 7
		ifp_event_t event_mode; // bits 6..5
		ifp_pd_sel_t chan_pd_sel; // bits 4..3
		logic readback_sel; // bit 2
		logic chan_rcv_sel; // bit 1
		logic clear_on_read_sel; // bit 0
	} ifp_irq_cfg_t;

	typedef struct packed {
		logic reserved; // bit 7, reads zero
		ifp_pd_sel_t dac_pd_sel; // bits 6..5
		logic dac_rcv_sel; // bit 4
		logic pd_flag; // bit 3, status only
		logic startup_ignore; // bit 2
		logic dac_detect_off; // bit 1
		logic reg_detect_off; // bit 0
	} ifp_dac_cfg_t;

	// ************************************************
	// fault power-down decision, shared by channel and dac paths
	// ************************************************
	function automatic logic ifp_pd_trigger(ifp_pd_sel_t sel, logic [7:0] faults, logic [7:0] mask);
		logic hit;
		hit = 1'b0;
		if (sel == PD_UNMASKED) begin
			hit = |(faults & ~mask);
		end else if (sel == PD_ALL) begin
			hit = |faults;
		end
		return hit;
	endfunction : ifp_pd_trigger

endpackage : ifp_pkg

// >>> hw/ifp_fault_hold.sv
// power-down hold flop with automatic or manual recovery
`timescale 1ns/10ps
module ifp_fault_hold (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	// control
	input wire logic trigger,
	input wire logic manual_rcv,
	input wire logic release_req,
	// state
	output logic powerdown
);

	// ************************************************
	// hold process
	// ************************************************
	// an active fault always wins over a release
	always_ff @(posedge mclk) begin
		if (srst) begin
			powerdown <= 1'b0;
		end else if (clk_en) begin
			if (trigger) begin
				powerdown <= 1'b1;
			end else if (!manual_rcv || release_req) begin
				powerdown <= 1'b0;
			end
		end
	end

endmodule : ifp_fault_hold

// >>> hw/ifp_irq_pulse.sv
// periodic and one-shot pulse timer for the interrupt pin
`timescale 1ns/10ps
module ifp_irq_pulse #(
	parameter int unsigned WIDTH_CYCLES = ifp_pkg::PULSE_WIDTH_CYCLES,
	parameter int unsigned PERIOD_CYCLES = ifp_pkg::PULSE_PERIOD_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	// control
	input wire logic periodic_mode,
	input wire logic periodic_cond,
	input wire logic oneshot_mode,
	input wire logic oneshot_trig,
	// pulse
	output logic pulse
);

	typedef enum logic [1:0] {
		PS_IDLE = 2'h0,
		PS_PERIODIC = 2'h1,
		PS_ONESHOT = 2'h2
	} ifp_pulse_state_t;

	ifp_pulse_state_t state; // timer state
	logic [ifp_pkg::PULSE_CNT_W-1:0] cnt; // cycles into pulse or period
	logic per_run; // periodic mode wants pulses
	logic per_wrap; // end of one period
	logic one_end; // end of one-shot pulse

	assign per_run = periodic_mode && periodic_cond;
	assign per_wrap = (cnt == ifp_pkg::PULSE_CNT_W'(PERIOD_CYCLES - 1));
	assign one_end = (cnt == ifp_pkg::PULSE_CNT_W'(WIDTH_CYCLES - 1));
	assign pulse = ((state == PS_PERIODIC) && (cnt < ifp_pkg::PULSE_CNT_W'(WIDTH_CYCLES))) || (state == PS_ONESHOT);

	// ************************************************
	// timer state machine
	// ************************************************
	// high for the first WIDTH_CYCLES of each period; a new trigger restarts a one-shot
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= PS_IDLE;
			cnt <= '0;
		end else if (clk_en) begin
			case (state)
				PS_IDLE: begin
					cnt <= '0;
					if (per_run) begin
						state <= PS_PERIODIC;
					end else if (oneshot_mode && oneshot_trig) begin
						state <= PS_ONESHOT;
					end
				end
				PS_PERIODIC: begin
					if (!per_run) begin
						state <= PS_IDLE;
					end else begin
						cnt <= per_wrap ? '0 : cnt + 1'b1;
					end
				end
				PS_ONESHOT: begin
					if (oneshot_mode && oneshot_trig) begin
						cnt <= '0;
					end else if (one_end) begin
						state <= PS_IDLE;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				default: begin
					state <= PS_IDLE;
				end
			endcase
		end
	end

endmodule : ifp_irq_pulse

// >>> hw/ifp_ctrl.sv
// interrupt pin control, latched flags and fault power-down with apb registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps

// What this block does
// - polarity bit chooses active-low or active-high pin
// - mode 0: pin follows unmasked latched flags
// - mode 1: pin follows unmasked live sources
// - mode 2: 2 ms pulse every 4 ms
// - mode 3: one 2 ms pulse per event
// - channel power-down select: none, unmasked, all
// - readback select hides masked latched bits
// - channel recovery automatic or manual
// - clear-on-read 0 clears only dead sources
// - clear-on-read 1 clears every read bit whose source is not still live
// - dac power-down select, resets to all
// - dac recovery manual by reset value
// - status bit shows dac faulted down
// - startup ignore keeps driver voltage faults during dac start-up from powering down the dac
// - dac detect-off suppresses dac faults
// - regulator detect-off suppresses regulator short
// - low ratio byte readable status
// - reserved dac register bit reads zero
// - upper six ratio bits readable status
module ifp_ctrl #(
	parameter int unsigned PULSE_WIDTH_CYCLES = ifp_pkg::PULSE_WIDTH_CYCLES,
	parameter int unsigned PULSE_PERIOD_CYCLES = ifp_pkg::PULSE_PERIOD_CYCLES
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	// apb slave
	input wire logic [ifp_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// fault sources, asynchronous
	input wire logic [ifp_pkg::SRC_CHAN_N-1:0] chan_fault,
	input wire logic driver_voltage_fault,
	input wire logic dac_short_fault,
	input wire logic regulator_short_fault,
	// same-clock status
	input wire logic dac_powering_up,
	input wire logic [13:0] frame_ratio,
	// outputs
	output logic irq_out,
	output logic chan_powerdown,
	output logic dac_powerdown,
	output logic dac_fault_detect_off,
	output logic regulator_short_detect_off
);

	// ************************************************
	// declarations
	// ************************************************
	ifp_pkg::ifp_irq_cfg_t irq_config; // irq and channel config
	ifp_pkg::ifp_dac_cfg_t dac_fault_config; // dac config, status overlaid on read
	logic [7:0] irq_mask; // 1 masks a source
	logic [7:0] latched_flags; // sticky flags
	logic [7:0] latched_snap; // latched flags at the pending read's setup, before any readback mask
	logic [7:0] frame_ratio_low_byte; // low byte captured with high read
	logic [7:0] sync1; // first synchroniser stage
	logic [7:0] sync2; // second synchroniser stage
	logic [7:0] live_q; // live flags one cycle ago
	logic [7:0] raw_src; // sources before synchronising
	logic [7:0] live; // gated, synchronised live flags
	logic [7:0] unmasked_live; // live and not masked
	logic [7:0] unmasked_latched; // latched and not masked
	logic [7:0] rd_clear; // bits cleared by a completed read
	logic [7:0] chan_faults; // faults that power down channels
	logic [7:0] dac_faults; // faults that power down the dac
	logic [7:0] wbyte; // write data low byte
	logic [7:0] idx; // register index from address
	logic [31:0] rd_val; // read mux result
	logic addr_ok; // word aligned and in range
	logic mapped; // index decodes to a register
	logic hit_ratio_high;
	logic hit_ratio_low;
	logic hit_irq_config;
	logic hit_dac_fault;
	logic hit_irq_mask;
	logic hit_latched;
	logic hit_live;
	logic hit_pd_release;
	logic setup; // apb setup phase
	logic access_done; // apb access completes this edge
	logic wr_done; // write takes effect this edge
	logic rd_done; // read completes this edge
	logic err_q; // pending transfer is unmapped
	logic chan_trig; // channel power-down requested
	logic dac_trig; // dac power-down requested
	logic vg_counted; // driver fault allowed to power down
	logic new_event; // rising unmasked live source
	logic pulse; // pulse timer output
	logic irq_active; // assertion before polarity
	logic next_irq_out; // pin level for next cycle
	logic rel_chan; // manual release of channels
	logic rel_dac; // manual release of dac

	// ************************************************
	// source synchronisers
	// ************************************************
	assign raw_src = {regulator_short_fault, dac_short_fault, driver_voltage_fault, chan_fault};

	// fault pins come from analog detectors, so two flops before any use
	always_ff @(posedge mclk) begin
		if (srst) begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
			live_q <= 8'h00;
		end else if (clk_en) begin
			sync1 <= raw_src;
			sync2 <= sync1;
			live_q <= live;
		end
	end

	// ************************************************
	// live flags with detector disables
	// ************************************************
	// a disabled detector never reports, so it cannot latch, interrupt or power down
	assign live[ifp_pkg::SRC_CHAN_N-1:0] = sync2[ifp_pkg::SRC_CHAN_N-1:0];
	assign live[ifp_pkg::SRC_DAC_VG] = sync2[ifp_pkg::SRC_DAC_VG] & ~dac_fault_config.dac_detect_off;
	assign live[ifp_pkg::SRC_DAC_SC] = sync2[ifp_pkg::SRC_DAC_SC] & ~dac_fault_config.dac_detect_off;
	assign live[ifp_pkg::SRC_AREG_SC] = sync2[ifp_pkg::SRC_AREG_SC] & ~dac_fault_config.reg_detect_off;
	assign dac_fault_detect_off = dac_fault_config.dac_detect_off;
	assign regulator_short_detect_off = dac_fault_config.reg_detect_off;

	assign unmasked_live = live & ~irq_mask;
	assign unmasked_latched = latched_flags & ~irq_mask;

	// ************************************************
	// apb decode
	// ************************************************
	assign idx = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ifp_pkg::ADDR_W-1:10] == '0);
	assign hit_ratio_high = addr_ok && (idx == ifp_pkg::IDX_RATIO_HIGH);
	assign hit_ratio_low = addr_ok && (idx == ifp_pkg::IDX_RATIO_LOW);
	assign hit_irq_config = addr_ok && (idx == ifp_pkg::IDX_IRQ_CONFIG);
	assign hit_dac_fault = addr_ok && (idx == ifp_pkg::IDX_DAC_FAULT);
	assign hit_irq_mask = addr_ok && (idx == ifp_pkg::IDX_IRQ_MASK);
	assign hit_latched = addr_ok && (idx == ifp_pkg::IDX_LATCHED);
	assign hit_live = addr_ok && (idx == ifp_pkg::IDX_LIVE);
	assign hit_pd_release = addr_ok && (idx == ifp_pkg::IDX_PD_RELEASE);

	// no wait state: read data is registered in setup, handed over in access
	assign setup = psel && !penable && clk_en;
	assign pready = clk_en;
	assign pslverr = psel && penable && err_q;
	assign access_done = psel && penable && clk_en;
	assign wr_done = access_done && pwrite && !err_q && pstrb[0];
	assign rd_done = access_done && !pwrite && !err_q;
	assign wbyte = pwdata[7:0];

	// ************************************************
	// read mux
	// ************************************************
	// status bit is live hardware state, never stored from a write
	always_comb begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		if (hit_ratio_high) begin
			rd_val = {26'h000_0000, frame_ratio[13:8]};
		end else if (hit_ratio_low) begin
			rd_val = {24'h00_0000, frame_ratio_low_byte};
		end else if (hit_irq_config) begin
			rd_val = {24'h00_0000, irq_config};
		end else if (hit_dac_fault) begin
			rd_val = {24'h00_0000, 1'b0, dac_fault_config.dac_pd_sel, dac_fault_config.dac_rcv_sel,
				dac_powerdown, dac_fault_config.startup_ignore, dac_fault_config.dac_detect_off,
				dac_fault_config.reg_detect_off};
		end else if (hit_irq_mask) begin
			rd_val = {24'h00_0000, irq_mask};
		end else if (hit_latched) begin
			rd_val = {24'h00_0000, irq_config.readback_sel ? unmasked_latched : latched_flags};
		end else if (hit_live) begin
			rd_val = {24'h00_0000, live};
		end else if (hit_pd_release) begin
			rd_val = 32'h0000_0000;
		end else begin
			mapped = 1'b0;
		end
	end

	// ************************************************
	// apb setup capture
	// ************************************************
	// the snapshot bounds clear-on-read to bits latched at setup, including bits hidden by readback select
	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
			err_q <= 1'b0;
			latched_snap <= 8'h00;
			frame_ratio_low_byte <= 8'h00;
		end else if (setup) begin
			err_q <= !mapped;
			if (!pwrite) begin
				prdata <= rd_val;
				latched_snap <= hit_latched ? latched_flags : 8'h00;
				if (hit_ratio_high) begin
					frame_ratio_low_byte <= frame_ratio[7:0];
				end
			end
		end
	end

	// ************************************************
	// configuration registers
	// ************************************************
	// reserved and status bits are never stored from write data
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_config <= ifp_pkg::ifp_irq_cfg_t'(ifp_pkg::IRQ_CONFIG_RESET);
			dac_fault_config <= ifp_pkg::ifp_dac_cfg_t'(ifp_pkg::DAC_FAULT_RESET);
			irq_mask <= ifp_pkg::IRQ_MASK_RESET;
		end else if (wr_done) begin
			if (hit_irq_config) begin
				irq_config <= ifp_pkg::ifp_irq_cfg_t'(wbyte);
			end else if (hit_dac_fault) begin
				dac_fault_config <= ifp_pkg::ifp_dac_cfg_t'({1'b0, wbyte[6:4], 1'b0, wbyte[2:0]});
			end else if (hit_irq_mask) begin
				irq_mask <= wbyte;
			end
		end
	end

	// release strobes last one cycle, on the completing write edge
	assign rel_chan = wr_done && hit_pd_release && wbyte[ifp_pkg::REL_CHAN_BIT];
	assign rel_dac = wr_done && hit_pd_release && wbyte[ifp_pkg::REL_DAC_BIT];

	// ************************************************
	// latched flags
	// ************************************************
	// mode 0 clears only bits whose source has gone; mode 1 clears all read bits except those a still-live source sets again
	assign rd_clear = !(rd_done && hit_latched) ? 8'h00 :
		irq_config.clear_on_read_sel ? latched_snap :
		(latched_snap & ~live);

	// a set in the clearing cycle wins, so no event is lost
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			always_ff @(posedge mclk) begin
				if (srst) begin
					latched_flags[gi] <= 1'b0;
				end else if (clk_en) begin
					if (live[gi]) begin
						latched_flags[gi] <= 1'b1;
					end else if (rd_clear[gi]) begin
						latched_flags[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ************************************************
	// fault power-down
	// ************************************************
	// channels and micbias react to their own faults and the regulator short
	assign chan_faults = {live[ifp_pkg::SRC_AREG_SC], 2'b00, live[ifp_pkg::SRC_CHAN_N-1:0]};
	// a driver voltage fault during dac start-up may be ignored
	assign vg_counted = live[ifp_pkg::SRC_DAC_VG] &
		~(dac_fault_config.startup_ignore & dac_powering_up);
	assign dac_faults = {1'b0, live[ifp_pkg::SRC_DAC_SC], vg_counted, 5'b0_0000};

	assign chan_trig = ifp_pkg::ifp_pd_trigger(irq_config.chan_pd_sel, chan_faults, irq_mask);
	assign dac_trig = ifp_pkg::ifp_pd_trigger(dac_fault_config.dac_pd_sel, dac_faults, irq_mask);

	// channel and micbias power-down
	ifp_fault_hold u_chan_hold (
		.mclk(mclk),
		.srst(srst),
		.clk_en(clk_en),
		.trigger(chan_trig),
		.manual_rcv(irq_config.chan_rcv_sel),
		.release_req(rel_chan),
		.powerdown(chan_powerdown)
	);

	// dac output power-down
	ifp_fault_hold u_dac_hold (
		.mclk(mclk),
		.srst(srst),
		.clk_en(clk_en),
		.trigger(dac_trig),
		.manual_rcv(dac_fault_config.dac_rcv_sel),
		.release_req(rel_dac),
		.powerdown(dac_powerdown)
	);

	// ************************************************
	// interrupt pin
	// ************************************************
	// a new event is a rising edge of any unmasked live source
	assign new_event = |(unmasked_live & ~(live_q & ~irq_mask));

	// pulse timer for the two pulsed modes
	ifp_irq_pulse #(
		.WIDTH_CYCLES(PULSE_WIDTH_CYCLES),
		.PERIOD_CYCLES(PULSE_PERIOD_CYCLES)
	) u_pulse (
		.mclk(mclk),
		.srst(srst),
		.clk_en(clk_en),
		.periodic_mode(irq_config.event_mode == ifp_pkg::EV_PERIODIC),
		.periodic_cond(|unmasked_latched),
		.oneshot_mode(irq_config.event_mode == ifp_pkg::EV_ONESHOT),
		.oneshot_trig(new_event),
		.pulse(pulse)
	);

	// mode selection before polarity
	always_comb begin
		case (irq_config.event_mode)
			ifp_pkg::EV_LATCHED: irq_active = |unmasked_latched;
			ifp_pkg::EV_LIVE: irq_active = |unmasked_live;
			default: irq_active = pulse;
		endcase
	end

	// registered pin; idle level is the inverse of the polarity bit
	assign next_irq_out = irq_config.polarity ? irq_active : ~irq_active;

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_out <= 1'b1;
		end else if (clk_en) begin
			irq_out <= next_irq_out;
		end
	end

endmodule : ifp_ctrl

// >>> verification/ifp_ctrl_props.sv
// assertion checker for the interrupt and fault power-down block
`timescale 1ns/10ps
module ifp_ctrl_props (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	// apb slave
	input wire logic [ifp_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// status and outputs
	input wire logic [13:0] frame_ratio,
	input wire logic irq_out,
	input wire logic chan_powerdown,
	input wire logic dac_powerdown,
	input wire logic dac_fault_detect_off,
	input wire logic regulator_short_detect_off
);
	// ************************************************
	// decode helpers
	// ************************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	wire rd_setup = psel && !penable && !pwrite && clk_en; // read setup edge
	wire wr_acc = psel && penable && pwrite && clk_en && pstrb[0]; // write takes effect

	// ************************************************
	// assertions
	// ************************************************
	reset_idle_a: assert property (@(posedge mclk) disable iff (1'b0)
		srst |=> irq_out && !chan_powerdown && !dac_powerdown) else $error("reset state wrong");
	err_in_access_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
	unmapped_err_a: assert property (psel && penable && paddr == 12'h1FC |-> pslverr) else $error("no error");
	ratio_high_a: assert property (rd_setup && paddr == 12'h100 |=>
		prdata == {26'h0, $past(frame_ratio[13:8])}) else $error("ratio high wrong");
	ratio_low_a: assert property (rd_setup && paddr == 12'h104 |=> prdata[31:8] == 24'h0)
		else $error("ratio low upper bits");
	reserved_zero_a: assert property (rd_setup && paddr == 12'h10C |=> prdata[31:7] == 25'h0)
		else $error("reserved bit set");
	dac_flag_a: assert property (rd_setup && paddr == 12'h10C |=> prdata[3] == $past(dac_powerdown))
		else $error("dac status flag wrong");
	detect_wr_a: assert property (wr_acc && paddr == 12'h10C |=> dac_fault_detect_off == $past(pwdata[1])
		&& regulator_short_detect_off == $past(pwdata[0])) else $error("detect-off bits wrong");
	// a stopped clock enable must hold the pin and both power-down outputs
	freeze_hold_a: assert property (!clk_en |-> !pready ##1
		($stable(irq_out) && $stable(chan_powerdown) && $stable(dac_powerdown))) else $error("state moved");
	cover property (rd_setup && paddr == 12'h184);
	cover property ($rose(dac_powerdown));
	cover property ($fell(irq_out));
endmodule : ifp_ctrl_props

bind ifp_ctrl ifp_ctrl_props i_ifp_ctrl_props (.*);

// >>> verification/ifp_host_model.sv
// apb host model that issues register reads and writes
`timescale 1ns/10ps
module ifp_host_model (
	// clock
	input wire logic mclk,
	// apb master side
	output logic [ifp_pkg::ADDR_W-1:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = '0;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end

	// one transfer: setup, then access held until pready is seen high
	task automatic xfer(input logic [ifp_pkg::ADDR_W-1:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : ifp_host_model

// >>> verification/tb_top.sv
// self-checking bench for the interrupt and fault power-down block
`timescale 1ns/10ps
module tb_top;
	localparam int unsigned PW = 4; // short pulse width
	localparam int unsigned PP = 8; // short pulse period
	logic mclk, srst, clk_en, psel, penable, pwrite, pready, pslverr, e;
	logic [ifp_pkg::ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb;
	logic [4:0] chan_fault;
	logic driver_voltage_fault, dac_short_fault, regulator_short_fault, dac_powering_up;
	logic [13:0] frame_ratio;
	logic irq_out, chan_powerdown, dac_powerdown, dac_fault_detect_off, regulator_short_detect_off;
	int error_cnt, checked, cyc, act;

	// ************************************************
	// clock, design and host
	// ************************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	ifp_ctrl #(.PULSE_WIDTH_CYCLES(PW), .PULSE_PERIOD_CYCLES(PP)) i_ifp_ctrl (.*);
	ifp_host_model i_ifp_host_model (.*);

	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			error_cnt++;
			$display("BAD %s exp %0h seen %0h", n, x, s);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		i_ifp_host_model.xfer(a, 1'b1, d, q, e);
	endtask : wr
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
		i_ifp_host_model.xfer(a, 1'b0, 8'h00, q, e);
		chk(n, q, x);
	endtask : rdc
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// counts cycles with the active-low pin asserted
	task automatic count_act(input int n);
		act = 0;
		repeat (n) begin
			@(posedge mclk);
			act += (irq_out === 1'b0);
		end
	endtask : count_act

	// hang guard, run needs well under 3000 cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		srst = 1'b1;
		clk_en = 1'b1;
		chan_fault = 5'h00;
		{driver_voltage_fault, dac_short_fault, regulator_short_fault, dac_powering_up} = 4'h0;
		frame_ratio = 14'h3A5C;
		tick(20);
		srst <= 1'b0;
		chk("irq_out", irq_out, 32'h1);
		rdc("irq_config", 12'h108, 32'h00);
		rdc("dac_fault_config", 12'h10C, 32'h54);
		rdc("unmapped", 12'h1FC, 32'h00);
		chk("slverr", e, 32'h1);
		rdc("ratio_high", 12'h100, 32'h3A);
		frame_ratio <= 14'h0000;
		rdc("ratio_low", 12'h104, 32'h5C);
		// live mode then polarity flip
		wr(12'h108, 8'h20);
		chan_fault <= 5'h01;
		tick(6);
		chk("irq_live", irq_out, 32'h0);
		wr(12'h108, 8'hA0);
		tick(2);
		chk("irq_pol", irq_out, 32'h1);
		chan_fault <= 5'h00;
		tick(6);
		chk("irq_live_off", irq_out, 32'h0);
		wr(12'h108, 8'h00);
		tick(2);
		chk("irq_latched", irq_out, 32'h0);
		// latched readback and clearing, bit1 kept live
		chan_fault <= 5'h02;
		tick(6);
		rdc("latched", 12'h184, 32'h03);
		wr(12'h180, 8'h02);
		wr(12'h108, 8'h04);
		rdc("latched_hidden", 12'h184, 32'h00);
		wr(12'h108, 8'h01);
		rdc("latched_live", 12'h184, 32'h02);
		chan_fault <= 5'h00;
		tick(6);
		rdc("latched_clr", 12'h184, 32'h02);
		rdc("latched_gone", 12'h184, 32'h00);
		// every channel select with the faulting source masked
		wr(12'h180, 8'h04);
		for (int s = 0; s < 4; s++) begin
			wr(12'h108, 8'(s << 3));
			chan_fault <= 5'h04;
			tick(6);
			chk("chan_pd", chan_powerdown, 32'(s == 2));
			chan_fault <= 5'h00;
			tick(6);
			chk("chan_auto", chan_powerdown, 32'h0);
		end
		wr(12'h180, 8'h00);
		wr(12'h108, 8'h12);
		chan_fault <= 5'h10;
		tick(6);
		chan_fault <= 5'h00;
		tick(6);
		chk("chan_hold", chan_powerdown, 32'h1);
		wr(12'h18C, 8'h01);
		tick(2);
		chk("chan_rel", chan_powerdown, 32'h0);
		// dac power-down with reset settings, then a frozen enable
		dac_short_fault <= 1'b1;
		tick(6);
		chk("dac_pd", dac_powerdown, 32'h1);
		rdc("dac_status", 12'h10C, 32'h5C);
		dac_short_fault <= 1'b0;
		tick(6);
		chk("dac_hold", dac_powerdown, 32'h1);
		clk_en <= 1'b0;
		tick(5);
		clk_en <= 1'b1;
		wr(12'h18C, 8'h02);
		tick(2);
		chk("dac_rel", dac_powerdown, 32'h0);
		// driver fault while the dac starts up
		dac_powering_up <= 1'b1;
		driver_voltage_fault <= 1'b1;
		tick(6);
		chk("dac_ignore", dac_powerdown, 32'h0);
		wr(12'h10C, 8'h40);
		tick(6);
		chk("dac_startup", dac_powerdown, 32'h1);
		driver_voltage_fault <= 1'b0;
		dac_powering_up <= 1'b0;
		tick(6);
		chk("dac_auto", dac_powerdown, 32'h0);
		// detection switched off
		wr(12'h10C, 8'h43);
		dac_short_fault <= 1'b1;
		regulator_short_fault <= 1'b1;
		tick(6);
		chk("dac_det_off", dac_powerdown, 32'h0);
		chk("reg_det_off", chan_powerdown, 32'h0);
		dac_short_fault <= 1'b0;
		wr(12'h10C, 8'h42);
		tick(6);
		chk("reg_det_on", chan_powerdown, 32'h1);
		regulator_short_fault <= 1'b0;
		tick(6);
		wr(12'h18C, 8'h01);
		// periodic pulses on a pending latched flag
		chan_fault <= 5'h01;
		tick(6);
		chan_fault <= 5'h00;
		wr(12'h108, 8'h40);
		tick(4);
		count_act(80);
		chk("irq_periodic", act, 32'(80 / PP * PW));
		// one pulse per new event
		wr(12'h108, 8'h60);
		tick(10);
		chan_fault <= 5'h08;
		count_act(40);
		chk("irq_oneshot", act, 32'(PW));
		report_and_stop();
	end
endmodule : tb_top
